/* File: design/table_search_pkg.sv */
// constants, types and behaviour summary for the table search engine
// Behaviour
// - single-word maximum scans first word to first plus length minus one, stores largest
// - single-word minimum scans same range, stores smallest value to destination
// - control bit 14 set writes result address to index register zero when background mode is off
// - equal extremes report the lowest address, first found in scan
// - control bit 15 set compares integer entries signed, otherwise unsigned
// - signed single words 8000 to ffff count as negative
// - background mode with control bit 14 set sends address to low and high background words
// - background mode sets background error bit on any error
// - double-word maximum scans length pairs, stores result to two words
// - double-word address reported is lower word of first best pair
// - double-word signed mode compares 32-bit two's complement values
// - error flag when length field is outside 0001 to ffff
// - double-word search sets zero flag when result equals zero
// - scan time grows with table length, one word per read
// - float maximum searches 32-bit floating entries, stores largest to two words
package table_search_pkg;
  localparam int AW = 16;
  localparam int DW = 16;
  localparam logic [15:0] OP_WORD_MAX  = 16'h00b6;
  localparam logic [15:0] OP_WORD_MIN  = 16'h00b7;
  localparam logic [15:0] OP_DWORD_MAX = 16'h00ae;
  localparam logic [15:0] OP_FLOAT_MAX = 16'h00b0;
  localparam int BIT_ADDR_OUT = 14;
  localparam int BIT_SIGNED   = 15;
  localparam logic [15:0] LEN_MIN = 16'h0001;

  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_OPCODE  = 5'h01;
  localparam logic [4:0] REG_CW0     = 5'h02;
  localparam logic [4:0] REG_CW1     = 5'h03;
  localparam logic [4:0] REG_FIRST   = 5'h04;
  localparam logic [4:0] REG_DEST    = 5'h05;
  localparam logic [4:0] REG_STATUS  = 5'h06;
  localparam logic [4:0] REG_IRQST   = 5'h07;
  localparam logic [4:0] REG_IRQMASK = 5'h08;
  localparam logic [4:0] REG_INDEX   = 5'h09;
  localparam logic [4:0] REG_BGLOW   = 5'h0a;
  localparam logic [4:0] REG_BGHIGH  = 5'h0b;
  localparam logic [4:0] REG_RESLO   = 5'h0c;
  localparam logic [4:0] REG_RESHI   = 5'h0d;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WAIT  = 3'b011,
    ST_WRLO  = 3'b010,
    ST_WRHI  = 3'b110,
    ST_DONE  = 3'b111
  } state_t;

  typedef struct packed {
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } mem_req_t;
endpackage

/* File: design/table_min_max_search.sv */
// table search engine with wishbone registers and data memory master
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module table_min_max_search
  import table_search_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_adr_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  output table_search_pkg::mem_req_t       memReq,
  input  wire logic                        memAck,
  input  wire logic [table_search_pkg::DW-1:0] memRdata,
  output logic                             irq
);
  import table_search_pkg::*;

  logic [15:0] opcode_q, cw0_q, cw1_q, first_q, dest_q;
  logic        bgEnable_q;
  logic [15:0] index_q, bgLow_q, bgHigh_q;
  logic [31:0] best_q;
  logic [15:0] bestAddr_q, addr_q, cnt_q, lowWord_q;
  logic        haveBest_q, half_q, busy_q;
  logic        errorFlag_q, zeroFlag_q, bgError_q;
  logic [1:0]  irqStatus_q, irqMask_q;
  state_t      state_q;
  mem_req_t    memReq_q;

  logic        wbHit, wbWr, startPulse, isDword, isSigned, doneEv, errEv, wrOk;
  logic [31:0] entry;
  logic        better;

  // float ordering via sign-magnitude key conversion
  function automatic logic [31:0] float_key(input logic [31:0] v);
    float_key = v[31] ? ~v : (v | 32'h80000000);
  endfunction

  function automatic logic beats(input logic [31:0] a, input logic [31:0] b,
                                 input logic sgn, input logic dw, input logic isMin,
                                 input logic flt);
    logic [31:0] x;
    logic [31:0] y;
    x = a;
    y = b;
    if (flt) begin
      x = float_key(a);
      y = float_key(b);
    end else if (!dw) begin
      x = {sgn & a[15] ? 16'hffff : 16'h0000, a[15:0]};
      y = {sgn & b[15] ? 16'hffff : 16'h0000, b[15:0]};
    end
    if (sgn && !flt) begin
      beats = isMin ? ($signed(x) < $signed(y)) : ($signed(x) > $signed(y));
    end else begin
      beats = isMin ? (x < y) : (x > y);
    end
  endfunction

  assign wbHit      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr       = wbHit & wb_we_i & wb_sel_i[0];
  assign startPulse = wbWr & (wb_adr_i[6:2] == REG_CTRL) & wb_dat_i[0] & ~busy_q;
  assign isDword    = (opcode_q == OP_DWORD_MAX) | (opcode_q == OP_FLOAT_MAX);
  assign isSigned   = cw1_q[BIT_SIGNED];
  assign entry      = isDword ? {memRdata, lowWord_q} : {16'h0000, memRdata};
  assign better     = ~haveBest_q | beats(entry, best_q, isSigned, isDword,
                        opcode_q == OP_WORD_MIN, opcode_q == OP_FLOAT_MAX);
  assign doneEv     = (state_q == ST_DONE);
  // a start with length zero is an error
  assign errEv      = startPulse & (cw0_q < LEN_MIN);
  assign wrOk       = wbWr;

  // configuration registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      opcode_q   <= OP_WORD_MAX;
      cw0_q      <= 16'h0000;
      cw1_q      <= 16'h0000;
      first_q    <= 16'h0000;
      dest_q     <= 16'h0000;
      bgEnable_q <= 1'b0;
    end else if (wrOk & ~busy_q) begin
      unique case (wb_adr_i[6:2])
        REG_CTRL:   bgEnable_q <= wb_dat_i[1];
        REG_OPCODE: opcode_q   <= wb_dat_i[15:0];
        REG_CW0:    cw0_q      <= wb_dat_i[15:0];
        REG_CW1:    cw1_q      <= wb_dat_i[15:0];
        REG_FIRST:  first_q    <= wb_dat_i[15:0];
        REG_DEST:   dest_q     <= wb_dat_i[15:0];
        default: ;
      endcase
    end
  end

  // scan sequencer; one memory read per word, so time grows with length
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      busy_q     <= 1'b0;
      addr_q     <= 16'h0000;
      cnt_q      <= 16'h0000;
      half_q     <= 1'b0;
      haveBest_q <= 1'b0;
      best_q     <= 32'h00000000;
      bestAddr_q <= 16'h0000;
      lowWord_q  <= 16'h0000;
      memReq_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // length below 0001 refuses the search
          if (startPulse && cw0_q >= LEN_MIN) begin
            busy_q     <= 1'b1;
            addr_q     <= first_q;
            cnt_q      <= cw0_q;
            half_q     <= 1'b0;
            haveBest_q <= 1'b0;
            memReq_q   <= '{req: 1'b1, we: 1'b0, addr: first_q, wdata: 16'h0000};
            state_q    <= ST_READ;
          end
        end
        ST_READ: begin
          if (memAck) begin
            memReq_q.req <= 1'b0;
            state_q      <= ST_WAIT;
            if (isDword && !half_q) begin
              lowWord_q <= memRdata;
            end else if (better) begin
              // address of lower word of first best
              best_q     <= entry;
              bestAddr_q <= isDword ? addr_q - 16'h0001 : addr_q;
              haveBest_q <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          if (!(isDword && !half_q)) begin
            cnt_q <= cnt_q - 16'h0001;
          end
          half_q <= isDword & ~half_q;
          addr_q <= addr_q + 16'h0001;
          if (!(isDword && !half_q) && cnt_q == 16'h0001) begin
            memReq_q <= '{req: 1'b1, we: 1'b1, addr: dest_q, wdata: best_q[15:0]};
            state_q  <= ST_WRLO;
          end else begin
            memReq_q <= '{req: 1'b1, we: 1'b0, addr: addr_q + 16'h0001, wdata: 16'h0000};
            state_q  <= ST_READ;
          end
        end
        ST_WRLO: begin
          if (memAck) begin
            memReq_q.req <= 1'b0;
            if (isDword) begin
              // request drops for a cycle between the two result writes
              memReq_q.addr  <= dest_q + 16'h0001;
              memReq_q.wdata <= best_q[31:16];
              state_q        <= ST_WRHI;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_WRHI: begin
          if (!memReq_q.req) begin
            memReq_q.req <= 1'b1;
          end else if (memAck) begin
            memReq_q.req <= 1'b0;
            state_q      <= ST_DONE;
          end
        end
        ST_DONE: begin
          busy_q  <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // result address, flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      index_q     <= 16'h0000;
      bgLow_q     <= 16'h0000;
      bgHigh_q    <= 16'h0000;
      errorFlag_q <= 1'b0;
      zeroFlag_q  <= 1'b0;
      bgError_q   <= 1'b0;
    end else begin
      if (startPulse) begin
        // zero length raises the error flag
        errorFlag_q <= (cw0_q < LEN_MIN);
        // background enable comes from this same start write
        if (wb_dat_i[1] && errEv) begin
          bgError_q <= 1'b1;
        end
      end
      if (doneEv) begin
        // address only when bit 14 set
        if (cw1_q[BIT_ADDR_OUT]) begin
          // background words take the address; high digits are zero here
          if (bgEnable_q) begin
            bgLow_q  <= bestAddr_q;
            bgHigh_q <= 16'h0000;
          end else begin
            index_q <= bestAddr_q;
          end
        end
        zeroFlag_q <= isDword & (best_q == 32'h00000000);
      end
      if (wrOk && wb_adr_i[6:2] == REG_STATUS && wb_dat_i[2]) begin
        bgError_q <= 1'b0;
      end
    end
  end

  // interrupts: bit0 done, bit1 error; set wins over write-one clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStatus_q <= 2'b00;
      irqMask_q   <= 2'b00;
      irq         <= 1'b0;
    end else begin
      irqStatus_q <= (irqStatus_q & ~((wrOk && wb_adr_i[6:2] == REG_IRQST) ? wb_dat_i[1:0]
                     : 2'b00)) | {errEv, doneEv};
      if (wrOk && wb_adr_i[6:2] == REG_IRQMASK) begin
        irqMask_q <= wb_dat_i[1:0];
      end
      irq <= |(irqStatus_q & irqMask_q);
    end
  end

  // wishbone answer: ack one cycle after request, unmapped reads zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbHit;
      wb_dat_o <= 32'h00000000;
      if (wbHit && !wb_we_i) begin
        unique case (wb_adr_i[6:2])
          REG_CTRL:    wb_dat_o <= {30'h0, bgEnable_q, busy_q};
          REG_OPCODE:  wb_dat_o <= {16'h0, opcode_q};
          REG_CW0:     wb_dat_o <= {16'h0, cw0_q};
          REG_CW1:     wb_dat_o <= {16'h0, cw1_q};
          REG_FIRST:   wb_dat_o <= {16'h0, first_q};
          REG_DEST:    wb_dat_o <= {16'h0, dest_q};
          REG_STATUS:  wb_dat_o <= {29'h0, bgError_q, zeroFlag_q, errorFlag_q};
          REG_IRQST:   wb_dat_o <= {30'h0, irqStatus_q};
          REG_IRQMASK: wb_dat_o <= {30'h0, irqMask_q};
          REG_INDEX:   wb_dat_o <= {16'h0, index_q};
          REG_BGLOW:   wb_dat_o <= {16'h0, bgLow_q};
          REG_BGHIGH:  wb_dat_o <= {16'h0, bgHigh_q};
          REG_RESLO:   wb_dat_o <= {16'h0, best_q[15:0]};
          REG_RESHI:   wb_dat_o <= {16'h0, best_q[31:16]};
          default:     wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  assign memReq = memReq_q;
endmodule // table_min_max_search

/* File: tb/table_search_sva.sv */
// assertions on the table search engine ports
`timescale 1ns/1ps
module table_search_sva
  import table_search_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_ack_o,
  input wire table_search_pkg::mem_req_t memReq,
  input wire logic                       memAck,
  input wire logic                       irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [15:0] last_q;
  logic        rdRun_q;
  logic        wrRun_q;
  // a write ends a scan, so the next operation starts a fresh run
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdRun_q <= 1'b0;
      wrRun_q <= 1'b0;
    end else if (memReq.req && memAck) begin
      rdRun_q <= !memReq.we;
      wrRun_q <= memReq.we;
      last_q  <= memReq.addr;
    end
  end
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without request");
  req_hold_a: assert property (memReq.req && !memAck |=> memReq.req && $stable(memReq.addr))
    else $error("memory request changed before accept");
  req_drop_a: assert property (memReq.req && memAck |=> !memReq.req)
    else $error("memory request not dropped after accept");
  scan_order_a: assert property ($rose(memReq.req) && !memReq.we && rdRun_q
    |-> memReq.addr == last_q + 16'h1)
    else $error("scan address not ascending by one");
  dest_pair_a: assert property ($rose(memReq.req) && memReq.we && wrRun_q
    |-> memReq.addr == last_q + 16'h1)
    else $error("second result word not at destination plus one");
  rst_quiet_a: assert property ($fell(sys_rst) |-> !memReq.req && !wb_ack_o && !irq)
    else $error("outputs active right after reset");
endmodule // table_search_sva

/* File: tb/table_mem_model.sv */
// word-addressed data memory answering the engine
`timescale 1ns/1ps
module table_mem_model
  import table_search_pkg::*;
(
  input wire logic                          clock,
  input wire logic                          sys_rst,
  input wire logic                          slow,
  input wire table_search_pkg::mem_req_t    memReq,
  output logic                              memAck,
  output logic [table_search_pkg::DW-1:0]   memRdata
);
  logic [15:0] words [0:255];
  logic [1:0]  wait_q;
  // read data is garbage outside an accept, so stale values are never trusted
  always @(posedge clock) begin
    if (sys_rst) begin
      memAck   <= 1'b0;
      wait_q   <= 2'h0;
      memRdata <= 16'h5a5a;
    end else if (!memReq.req || memAck) begin
      memAck   <= 1'b0;
      wait_q   <= 2'h0;
      memRdata <= ~memRdata;
    end else if (wait_q == (slow ? 2'h3 : 2'h0)) begin
      memAck   <= 1'b1;
      memRdata <= words[memReq.addr[7:0]];
      if (memReq.we) words[memReq.addr[7:0]] <= memReq.wdata;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule // table_mem_model

/* File: tb/tb.sv */
// self-checking bench for the table search engine
`timescale 1ns/1ps
module tb;
  import table_search_pkg::*;
  typedef struct packed {
    logic [15:0] op, cw1, len, first, res, resHi, idx;
    logic [2:0]  stat;
  } row_t;
  logic clock, sys_rst, cyc, we, ack, memAck, irq, slow;
  logic [4:0]  adr;
  logic [15:0] wdat, memRdata;
  logic [31:0] rdat;
  mem_req_t    memReq;
  int          checked, nMismatch;
  row_t rows [9] = '{
    '{OP_WORD_MAX, 16'h4000, 16'h6, 16'h10, 16'hffff, 16'h0, 16'h15, 3'h0},
    '{OP_WORD_MAX, 16'h8000, 16'h6, 16'h10, 16'h7fff, 16'h0, 16'h15, 3'h0},
    '{OP_WORD_MAX, 16'hc000, 16'h6, 16'h10, 16'h7fff, 16'h0, 16'h12, 3'h0},
    '{OP_WORD_MIN, 16'h4000, 16'h6, 16'h10, 16'h0001, 16'h0, 16'h14, 3'h0},
    '{OP_WORD_MIN, 16'hc000, 16'h6, 16'h10, 16'h8000, 16'h0, 16'h11, 3'h0},
    '{OP_DWORD_MAX, 16'h4000, 16'h3, 16'h10, 16'h0001, 16'hffff, 16'h14, 3'h0},
    '{OP_DWORD_MAX, 16'hc000, 16'h3, 16'h10, 16'h7fff, 16'h7fff, 16'h12, 3'h0},
    '{OP_DWORD_MAX, 16'h4000, 16'h1, 16'h16, 16'h0, 16'h0, 16'h16, 3'h2},
    '{OP_FLOAT_MAX, 16'h4000, 16'h3, 16'h10, 16'h7fff, 16'h7fff, 16'h12, 3'h0}};
  table_min_max_search DUT (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i({25'h0, adr, 2'b00}),
    .wb_dat_i({16'h0, wdat}), .wb_dat_o(rdat), .wb_ack_o(ack), .memReq(memReq),
    .memAck(memAck), .memRdata(memRdata), .irq(irq));
  table_mem_model MEM (.clock(clock), .sys_rst(sys_rst), .slow(slow), .memReq(memReq),
    .memAck(memAck), .memRdata(memRdata));
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= wd;
    do @(posedge clock); while (ack !== 1'b1);
    rd = rdat[15:0];
    cyc <= 1'b0;
    @(posedge clock);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic runOp(input row_t r, input logic [15:0] ctl);
    logic [15:0] d;
    xfer(1'b1, REG_OPCODE, r.op, d);
    xfer(1'b1, REG_CW0, r.len, d);
    xfer(1'b1, REG_CW1, r.cw1, d);
    xfer(1'b1, REG_FIRST, r.first, d);
    xfer(1'b1, REG_DEST, 16'h0040, d);
    xfer(1'b1, REG_CTRL, ctl, d);
    d = 16'h0001;
    while (d[0] !== 1'b0) xfer(1'b0, REG_CTRL, 16'h0, d);
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #100000;
    nMismatch++;
    testDone;
  end
  initial begin
    row_t        r;
    logic [15:0] d;
    static logic [15:0] tbl [8] = '{16'h0003, 16'h8000, 16'h7fff, 16'h7fff,
                             16'h0001, 16'hffff, 16'h0000, 16'h0000};
    {sys_rst, cyc, we, adr, wdat, slow} = {1'b1, 24'h0};
    foreach (tbl[k]) MEM.words[16 + k] = tbl[k];
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    xfer(1'b0, REG_STATUS, 16'h0, d);
    chk(d, 16'h0);
    chk({15'h0, irq}, 16'h0);
    xfer(1'b1, 5'h1f, 16'hffff, d);
    xfer(1'b0, 5'h1f, 16'h0, d);
    chk(d, 16'h0);
    xfer(1'b1, REG_IRQMASK, 16'h0001, d);
    foreach (rows[i]) begin
      r = rows[i];
      slow <= i[0];
      runOp(r, 16'h0001);
      xfer(1'b0, REG_RESLO, 16'h0, d);
      chk(d, r.res);
      xfer(1'b0, REG_RESHI, 16'h0, d);
      chk(d, r.resHi);
      chk(MEM.words[8'h40], r.res);
      if (r.op inside {OP_DWORD_MAX, OP_FLOAT_MAX}) chk(MEM.words[8'h41], r.resHi);
      xfer(1'b0, REG_INDEX, 16'h0, d);
      chk(d, r.idx);
      xfer(1'b0, REG_STATUS, 16'h0, d);
      chk(d & 16'h7, {13'h0, r.stat});
      chk({15'h0, irq}, 16'h1);
      xfer(1'b1, REG_IRQST, 16'h0003, d);
      repeat (2) @(posedge clock);
      chk({15'h0, irq}, 16'h0);
    end
    runOp(rows[0], 16'h0003);
    xfer(1'b0, REG_BGLOW, 16'h0, d);
    chk(d, 16'h0015);
    xfer(1'b0, REG_BGHIGH, 16'h0, d);
    chk(d, 16'h0);
    xfer(1'b0, REG_INDEX, 16'h0, d);
    chk(d, 16'h0012);
    xfer(1'b1, REG_IRQMASK, 16'h0, d);
    r = rows[0];
    r.len = 16'h0;
    runOp(r, 16'h0003);
    xfer(1'b0, REG_STATUS, 16'h0, d);
    chk(d & 16'h7, 16'h5);
    xfer(1'b0, REG_IRQST, 16'h0, d);
    chk(d & 16'h2, 16'h2);
    chk({15'h0, irq}, 16'h0);
    xfer(1'b1, REG_STATUS, 16'h0004, d);
    xfer(1'b0, REG_STATUS, 16'h0, d);
    chk(d & 16'h4, 16'h0);
    // reset in mid-scan abandons the search and clears the result registers
    xfer(1'b1, REG_CW0, 16'h0006, d);
    xfer(1'b1, REG_CTRL, 16'h0001, d);
    repeat (4) @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk({15'h0, memReq.req}, 16'h0);
    xfer(1'b0, REG_CTRL, 16'h0, d);
    chk(d, 16'h0);
    xfer(1'b0, REG_INDEX, 16'h0, d);
    chk(d, 16'h0);
    testDone;
  end
endmodule // tb
bind table_min_max_search table_search_sva CHK (.clock(clock), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .memReq(memReq),
  .memAck(memAck), .irq(irq));
